// File: include/efr_pkg.sv
// Constants and types of the extended function register bridge
// Behaviour
// - Every output register captures on the rising clock edge; the asynchronous active-low reset clears all but the ramp length, which loads 2048.
// - Volume slew code 0, 1 and 2 select ramp lengths of 2048, 4096 and 8192 steps.
// - Bit 10 of the DSP RAM address picks coefficient memory or data memory.
// - The 54-bit DSP result is read as byte registers, the top one holding bits 53 to 48.
// - Reading a result byte returns the live DSP output lines with no holding register.
// - The microcontroller drives a 54-bit word to the DSP through byte registers, the top one bits 53 to 48.
// - A two-register address, upper register bits 13 to 8, sets the DSP RAM location of the next transfer.
// - A 4-bit register drives the delay memory select lines.
// - The delay memory address is an 8-bit low register and a 5-bit high register.
// - A 3-bit register names the volume channel the volume settings apply to.
// - An 8-bit register carries the serial bit clock configuration field to the clock block.
package efr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int WORD_W = 54;
  localparam int RAM_ADDR_W = 14;
  localparam int DLY_ADDR_W = 13;
  localparam int RAMP_W = 14;

  localparam logic [7:0] OFF_BCLK = 8'ha2;
  localparam logic [7:0] OFF_DSEL = 8'ha3;
  localparam logic [7:0] OFF_DLO = 8'ha4;
  localparam logic [7:0] OFF_DHI = 8'ha5;
  localparam logic [7:0] OFF_SLEW = 8'ha6;
  localparam logic [7:0] OFF_CHAN = 8'ha7;
  localparam logic [7:0] OFF_VAUX = 8'ha9;
  localparam logic [7:0] OFF_VCA = 8'haa;
  localparam logic [7:0] OFF_VCB = 8'hab;
  localparam logic [7:0] OFF_VCC = 8'hac;
  localparam logic [7:0] OFF_RES0 = 8'had;
  localparam logic [7:0] OFF_RES1 = 8'hae;
  localparam logic [7:0] OFF_RES2 = 8'haf;
  localparam logic [7:0] OFF_RES3 = 8'hb1;
  localparam logic [7:0] OFF_RES4 = 8'hb2;
  localparam logic [7:0] OFF_RES5 = 8'hb0;
  localparam logic [7:0] OFF_RES6 = 8'hb8;
  localparam logic [7:0] OFF_WR0 = 8'hb3;
  localparam logic [7:0] OFF_WR1 = 8'hb4;
  localparam logic [7:0] OFF_WR2 = 8'hb5;
  localparam logic [7:0] OFF_WR3 = 8'hb6;
  localparam logic [7:0] OFF_WR4 = 8'hb7;
  localparam logic [7:0] OFF_WR5 = 8'hb9;
  localparam logic [7:0] OFF_WR6 = 8'hba;
  localparam logic [7:0] OFF_RLO = 8'hbb;
  localparam logic [7:0] OFF_RHI = 8'hbc;

  localparam int MEM_SEL_BIT = 10;
  localparam logic [7:0] RST_VAL = 8'h00;

  localparam logic [RAMP_W-1:0] RAMP_CODE0 = 14'h0800;
  localparam logic [RAMP_W-1:0] RAMP_CODE1 = 14'h1000;
  localparam logic [RAMP_W-1:0] RAMP_CODE2 = 14'h2000;

  typedef struct packed {
    logic [3:0] sel;
    logic [DLY_ADDR_W-1:0] addr;
  } efr_dly_type;

  typedef struct packed {
    logic [1:0] slew;
    logic [RAMP_W-1:0] ramp_len;
    logic [2:0] chan;
    logic [7:0] aux;
    logic [19:0] coeff;
  } efr_vol_type;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic [RAM_ADDR_W-1:0] addr;
    logic coef_sel;
  } efr_dsp_type;

endpackage

// File: rtl/efr_bridge.sv
// Extended function register bank between the microcontroller and the audio DSP
`timescale 1ns/1ps

module efr_bridge
  import efr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [ADDR_W-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [DATA_W-1:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [DATA_W-1:0] sfr_rdata_o,
  input wire logic [WORD_W-1:0] dsp_result_word_i,
  output logic [7:0] bit_clock_config_o,
  output efr_dly_type dly_o,
  output efr_vol_type vol_o,
  output efr_dsp_type dsp_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  function automatic logic [RAMP_W-1:0] ramp_len(input logic [1:0] code);
    case (code)
      2'h0: ramp_len = RAMP_CODE0;
      2'h1: ramp_len = RAMP_CODE1;
      2'h2: ramp_len = RAMP_CODE2;
      default: ramp_len = RAMP_CODE2;
    endcase
  endfunction

  logic wr_bclk;
  logic wr_dsel;
  logic wr_dlo;
  logic wr_dhi;
  logic wr_slew;
  logic wr_chan;
  logic wr_vaux;
  logic wr_vca;
  logic wr_vcb;
  logic wr_vcc;
  logic wr_rlo;
  logic wr_rhi;
  logic [6:0] wr_word;

  assign wr_bclk = sfr_wr_i && hit(sfr_addr_i, OFF_BCLK);
  assign wr_dsel = sfr_wr_i && hit(sfr_addr_i, OFF_DSEL);
  assign wr_dlo = sfr_wr_i && hit(sfr_addr_i, OFF_DLO);
  assign wr_dhi = sfr_wr_i && hit(sfr_addr_i, OFF_DHI);
  assign wr_slew = sfr_wr_i && hit(sfr_addr_i, OFF_SLEW);
  assign wr_chan = sfr_wr_i && hit(sfr_addr_i, OFF_CHAN);
  assign wr_vaux = sfr_wr_i && hit(sfr_addr_i, OFF_VAUX);
  assign wr_vca = sfr_wr_i && hit(sfr_addr_i, OFF_VCA);
  assign wr_vcb = sfr_wr_i && hit(sfr_addr_i, OFF_VCB);
  assign wr_vcc = sfr_wr_i && hit(sfr_addr_i, OFF_VCC);
  assign wr_rlo = sfr_wr_i && hit(sfr_addr_i, OFF_RLO);
  assign wr_rhi = sfr_wr_i && hit(sfr_addr_i, OFF_RHI);
  assign wr_word[0] = sfr_wr_i && hit(sfr_addr_i, OFF_WR0);
  assign wr_word[1] = sfr_wr_i && hit(sfr_addr_i, OFF_WR1);
  assign wr_word[2] = sfr_wr_i && hit(sfr_addr_i, OFF_WR2);
  assign wr_word[3] = sfr_wr_i && hit(sfr_addr_i, OFF_WR3);
  assign wr_word[4] = sfr_wr_i && hit(sfr_addr_i, OFF_WR4);
  assign wr_word[5] = sfr_wr_i && hit(sfr_addr_i, OFF_WR5);
  assign wr_word[6] = sfr_wr_i && hit(sfr_addr_i, OFF_WR6);

  ////////////////////////////////////////////////////////////////////////////
  // Clock block field

  logic [7:0] bclk_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bclk_ff <= RST_VAL;
    end else if (wr_bclk) begin
      bclk_ff <= sfr_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Delay memory select and address

  logic [3:0] dsel_ff;
  logic [7:0] dlo_ff;
  logic [4:0] dhi_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dsel_ff <= 4'h0;
      dlo_ff <= RST_VAL;
      dhi_ff <= 5'h00;
    end else begin
      if (wr_dsel) begin
        dsel_ff <= sfr_wdata_i[3:0];
      end
      if (wr_dlo) begin
        dlo_ff <= sfr_wdata_i;
      end
      if (wr_dhi) begin
        dhi_ff <= sfr_wdata_i[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Volume controls

  logic [1:0] slew_ff;
  logic [RAMP_W-1:0] ramp_ff;
  logic [2:0] chan_ff;
  logic [7:0] vaux_ff;
  logic [7:0] vca_ff;
  logic [7:0] vcb_ff;
  logic [3:0] vcc_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slew_ff <= 2'h0;
      ramp_ff <= RAMP_CODE0;
    end else if (wr_slew) begin
      slew_ff <= sfr_wdata_i[1:0];
      ramp_ff <= ramp_len(sfr_wdata_i[1:0]);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chan_ff <= 3'h0;
      vaux_ff <= RST_VAL;
      vca_ff <= RST_VAL;
      vcb_ff <= RST_VAL;
      vcc_ff <= 4'h0;
    end else begin
      if (wr_chan) begin
        chan_ff <= sfr_wdata_i[2:0];
      end
      if (wr_vaux) begin
        vaux_ff <= sfr_wdata_i;
      end
      if (wr_vca) begin
        vca_ff <= sfr_wdata_i;
      end
      if (wr_vcb) begin
        vcb_ff <= sfr_wdata_i;
      end
      if (wr_vcc) begin
        vcc_ff <= sfr_wdata_i[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word and RAM address toward the DSP

  logic [7:0] wbyte_ff [7];
  logic [7:0] rlo_ff;
  logic [7:0] rhi_ff;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 7; i++) begin
        wbyte_ff[i] <= RST_VAL;
      end
    end else begin
      for (int i = 0; i < 7; i++) begin
        if (wr_word[i]) begin
          wbyte_ff[i] <= sfr_wdata_i;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rlo_ff <= RST_VAL;
      rhi_ff <= RST_VAL;
    end else begin
      if (wr_rlo) begin
        rlo_ff <= sfr_wdata_i;
      end
      if (wr_rhi) begin
        rhi_ff <= sfr_wdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [RAM_ADDR_W-1:0] ram_addr;

  assign ram_addr = {rhi_ff[5:0], rlo_ff};
  assign bit_clock_config_o = bclk_ff;
  assign dly_o.sel = dsel_ff;
  assign dly_o.addr = {dhi_ff, dlo_ff};
  assign vol_o.slew = slew_ff;
  assign vol_o.ramp_len = ramp_ff;
  assign vol_o.chan = chan_ff;
  assign vol_o.aux = vaux_ff;
  assign vol_o.coeff = {vcc_ff, vcb_ff, vca_ff};
  assign dsp_o.word = {wbyte_ff[6][5:0], wbyte_ff[5], wbyte_ff[4], wbyte_ff[3],
                       wbyte_ff[2], wbyte_ff[1], wbyte_ff[0]};
  assign dsp_o.addr = ram_addr;
  assign dsp_o.coef_sel = ram_addr[MEM_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Read path, result bytes from live DSP lines with no holding register

  always_comb begin
    sfr_rdata_o = 8'h00;
    if (sfr_rd_i) begin
      case (sfr_addr_i)
        OFF_BCLK: sfr_rdata_o = bclk_ff;
        OFF_DSEL: sfr_rdata_o = {4'h0, dsel_ff};
        OFF_DLO: sfr_rdata_o = dlo_ff;
        OFF_DHI: sfr_rdata_o = {3'h0, dhi_ff};
        OFF_SLEW: sfr_rdata_o = {6'h00, slew_ff};
        OFF_CHAN: sfr_rdata_o = {5'h00, chan_ff};
        OFF_VAUX: sfr_rdata_o = vaux_ff;
        OFF_VCA: sfr_rdata_o = vca_ff;
        OFF_VCB: sfr_rdata_o = vcb_ff;
        OFF_VCC: sfr_rdata_o = {4'h0, vcc_ff};
        OFF_RES0: sfr_rdata_o = dsp_result_word_i[7:0];
        OFF_RES1: sfr_rdata_o = dsp_result_word_i[15:8];
        OFF_RES2: sfr_rdata_o = dsp_result_word_i[23:16];
        OFF_RES3: sfr_rdata_o = dsp_result_word_i[31:24];
        OFF_RES4: sfr_rdata_o = dsp_result_word_i[39:32];
        OFF_RES5: sfr_rdata_o = dsp_result_word_i[47:40];
        OFF_RES6: sfr_rdata_o = {2'h0, dsp_result_word_i[53:48]};
        OFF_WR0: sfr_rdata_o = wbyte_ff[0];
        OFF_WR1: sfr_rdata_o = wbyte_ff[1];
        OFF_WR2: sfr_rdata_o = wbyte_ff[2];
        OFF_WR3: sfr_rdata_o = wbyte_ff[3];
        OFF_WR4: sfr_rdata_o = wbyte_ff[4];
        OFF_WR5: sfr_rdata_o = wbyte_ff[5];
        OFF_WR6: sfr_rdata_o = wbyte_ff[6];
        OFF_RLO: sfr_rdata_o = rlo_ff;
        OFF_RHI: sfr_rdata_o = rhi_ff;
        default: sfr_rdata_o = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_write(logic [7:0] off);
    sfr_wr_i && (sfr_addr_i == off);
  endsequence

  sequence s_read(logic [7:0] off);
    sfr_rd_i && (sfr_addr_i == off);
  endsequence

  property p_reset_clear;
    @(posedge core_clk_i) disable iff (1'b0)
      !rstn_i |-> (bit_clock_config_o == 8'h00) && (dsp_o.word == '0) && (dly_o.addr == '0);
  endproperty

  a_reset_clears_out: assert property (p_reset_clear)
    else $error("outputs not clear in reset");

  a_slew_ramp_len: assert property (s_write(OFF_SLEW) |=> vol_o.ramp_len ==
      (($past(sfr_wdata_i[1:0]) == 2'h0) ? 14'h0800 :
       ($past(sfr_wdata_i[1:0]) == 2'h1) ? 14'h1000 : 14'h2000))
    else $error("ramp length does not match slew code");

  a_mem_sel_bit: assert property (s_write(OFF_RHI) |=> dsp_o.coef_sel == $past(sfr_wdata_i[2]))
    else $error("memory select not from address bit 10");

  a_result_top_byte: assert property (s_read(OFF_RES6)
      |-> sfr_rdata_o == {2'h0, dsp_result_word_i[53:48]})
    else $error("top result byte wrong");

  a_result_live_read: assert property (s_read(OFF_RES0) ##1 s_read(OFF_RES0)
      |-> sfr_rdata_o == dsp_result_word_i[7:0])
    else $error("result byte not live");

  a_word_top_bits: assert property (s_write(OFF_WR6) |=> dsp_o.word[53:48] == $past(sfr_wdata_i[5:0]))
    else $error("top word bits not written");

  a_word_holds: assert property (!sfr_wr_i [*2] |-> $stable(dsp_o.word))
    else $error("word changed without write");

  a_ram_addr_high: assert property (s_write(OFF_RHI) |=> dsp_o.addr[13:8] == $past(sfr_wdata_i[5:0]))
    else $error("RAM address high bits wrong");

  a_dly_select: assert property (s_write(OFF_DSEL) |=> dly_o.sel == $past(sfr_wdata_i[3:0]))
    else $error("delay select not updated");

  a_dly_addr_hi: assert property (s_write(OFF_DHI) |=> dly_o.addr[12:8] == $past(sfr_wdata_i[4:0]))
    else $error("delay address high bits wrong");

  a_vol_channel: assert property (s_write(OFF_CHAN) |=> vol_o.chan == $past(sfr_wdata_i[2:0]))
    else $error("volume channel not updated");

  a_bclk_field: assert property (s_write(OFF_BCLK) |=> bit_clock_config_o == $past(sfr_wdata_i))
    else $error("bit clock field not updated");

endmodule

// File: sim/efr_dsp_model.sv
// Behavioural model of the DSP core that echoes the written word back on its result lines
`timescale 1ns/1ps

module efr_dsp_model
  import efr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire efr_dsp_type dsp_i,
  input wire logic slow_i,
  output logic [WORD_W-1:0] result_word_o
);
  logic [WORD_W-1:0] stage_ff [3];

  ////////////////////////////////////////////////////////////////////////////////
  // Fast mode answers one cycle after the word lands, slow mode three cycles after
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage_ff <= '{default: '0};
    end else begin
      stage_ff[0] <= dsp_i.word;
      stage_ff[1] <= stage_ff[0];
      stage_ff[2] <= stage_ff[1];
    end
  end

  assign result_word_o = slow_i ? stage_ff[2] : stage_ff[0];
endmodule

// File: sim/tb_top.sv
// Self-checking bench for the extended function register bridge
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
  end \
end

module tb_top
  import efr_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rstn_i = 1'b1;
  logic [ADDR_W-1:0] sfr_addr_i = '0;
  logic sfr_wr_i = 1'b0;
  logic [DATA_W-1:0] sfr_wdata_i = '0;
  logic sfr_rd_i = 1'b0;
  logic slow = 1'b0;
  logic [DATA_W-1:0] sfr_rdata_o;
  logic [WORD_W-1:0] result_word;
  logic [7:0] bit_clock_config_o;
  efr_dly_type dly_o;
  efr_vol_type vol_o;
  efr_dsp_type dsp_o;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] rd_val;
  localparam logic [WORD_W-1:0] WORD_A = 54'h2a5c6d7e8f9102;

  always #5 core_clk_i = ~core_clk_i;

  efr_bridge efr_bridge_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
    .dsp_result_word_i(result_word), .bit_clock_config_o(bit_clock_config_o), .dly_o(dly_o),
    .vol_o(vol_o), .dsp_o(dsp_o));

  efr_dsp_model efr_dsp_model_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .dsp_i(dsp_o),
    .slow_i(slow), .result_word_o(result_word));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    sfr_wr_i = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_i);
    #1;
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    #2;
    `CHK("rdata", exp, sfr_rdata_o)
    @(posedge core_clk_i);
    #1;
    sfr_rd_i = 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_reset();
    `CHK("bclk", 8'h00, bit_clock_config_o)
    `CHK("dly", 17'h0, dly_o)
    `CHK("vol", {2'h0, RAMP_CODE0, 31'h0}, vol_o)
    `CHK("dsp", 69'h0, dsp_o)
    `CHK("rdata idle", 8'h00, sfr_rdata_o)
  endtask

  task automatic check_ctrl();
    wr_reg(OFF_BCLK, 8'h5a);
    wr_reg(OFF_DSEL, 8'hf7);
    wr_reg(OFF_DLO, 8'h3c);
    wr_reg(OFF_DHI, 8'hff);
    wr_reg(OFF_CHAN, 8'hfd);
    wr_reg(OFF_VAUX, 8'h96);
    wr_reg(OFF_VCA, 8'h12);
    wr_reg(OFF_VCB, 8'h34);
    wr_reg(OFF_VCC, 8'hf9);
    `CHK("bclk", 8'h5a, bit_clock_config_o)
    `CHK("dly sel", 4'h7, dly_o.sel)
    `CHK("dly addr", 13'h1f3c, dly_o.addr)
    `CHK("chan", 3'h5, vol_o.chan)
    `CHK("aux", 8'h96, vol_o.aux)
    `CHK("coeff", 20'h93412, vol_o.coeff)
    rd_chk(OFF_DSEL, 8'h07);
    rd_chk(OFF_DHI, 8'h1f);
    rd_chk(OFF_BCLK, 8'h5a);
  endtask

  task automatic check_slew();
    logic [RAMP_W-1:0] exp;
    for (int c = 0; c < 4; c++) begin
      wr_reg(OFF_SLEW, 8'(c));
      exp = (c == 0) ? 14'h0800 : (c == 1) ? 14'h1000 : 14'h2000;
      `CHK("slew", 2'(c), vol_o.slew)
      `CHK("ramp", exp, vol_o.ramp_len)
    end
  endtask

  task automatic check_word();
    logic [7:0] wofs [7];
    logic [7:0] rofs [7];
    wofs = '{OFF_WR0, OFF_WR1, OFF_WR2, OFF_WR3, OFF_WR4, OFF_WR5, OFF_WR6};
    rofs = '{OFF_RES0, OFF_RES1, OFF_RES2, OFF_RES3, OFF_RES4, OFF_RES5, OFF_RES6};
    // All bytes go in before the word is used
    for (int i = 0; i < 6; i++) wr_reg(wofs[i], WORD_A[i*8 +: 8]);
    wr_reg(OFF_WR6, {2'b11, WORD_A[53:48]});
    `CHK("word", WORD_A, dsp_o.word)
    rd_chk(OFF_WR6, {2'b11, WORD_A[53:48]});
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < 6; i++) rd_chk(rofs[i], WORD_A[i*8 +: 8]);
    rd_chk(OFF_RES6, {2'b00, WORD_A[53:48]});
    wr_reg(OFF_WR0, 8'hc3);
    @(posedge core_clk_i);
    #1;
    sfr_addr_i = OFF_RES0;
    sfr_rd_i = 1'b1;
    #2;
    `CHK("live fast", 8'hc3, sfr_rdata_o)
    @(posedge core_clk_i);
    #1;
    slow = 1'b1;
    #2;
    `CHK("live slow", WORD_A[7:0], sfr_rdata_o)
    @(posedge core_clk_i);
    #1;
    sfr_rd_i = 1'b0;
    slow = 1'b0;
    #2;
    `CHK("rd low", 8'h00, sfr_rdata_o)
  endtask

  task automatic check_ram_addr();
    wr_reg(OFF_RLO, 8'h5a);
    wr_reg(OFF_RHI, 8'hc4);
    `CHK("ram addr", 14'h045a, dsp_o.addr)
    `CHK("coef sel", 1'b1, dsp_o.coef_sel)
    wr_reg(OFF_RHI, 8'h3b);
    `CHK("ram addr", 14'h3b5a, dsp_o.addr)
    `CHK("coef sel", 1'b0, dsp_o.coef_sel)
    rd_chk(OFF_RHI, 8'h3b);
  endtask

  task automatic check_refused();
    wr_reg(OFF_RES0, 8'hff);
    wr_reg(8'ha8, 8'hff);
    rd_chk(8'ha8, 8'h00);
    `CHK("bclk kept", 8'h5a, bit_clock_config_o)
    `CHK("dly kept", 13'h1f3c, dly_o.addr)
    `CHK("word kept", {WORD_A[53:8], 8'hc3}, dsp_o.word)
  endtask

  task automatic check_async_reset();
    @(posedge core_clk_i);
    #1;
    rstn_i = 1'b0;
    #1;
    check_reset();
    repeat (3) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    @(posedge core_clk_i);
    #1;
    `CHK("bclk after", 8'h00, bit_clock_config_o)
    wr_reg(OFF_BCLK, 8'h81);
    `CHK("bclk new", 8'h81, bit_clock_config_o)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    // Falling edge after time zero so every flop resets before the first clock edge
    #1;
    rstn_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1;
    rstn_i = 1'b1;
    check_reset();
    check_ctrl();
    check_slew();
    check_word();
    check_ram_addr();
    check_refused();
    check_async_reset();
    complete_run();
  end

  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
endmodule
